// ### src/sma_addr_xfer.sv
// Two-wire serial engine with address recognition and master transfers.
`timescale 1ns/1ps
module sma_addr_xfer (
	// Register side clock, reset and freeze.
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Special-function register port.
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Link clock.
	input wire logic link_clk,
	// Open-drain bus pins.
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n
);
	sma_pkg::sma_core_st_t cq;
	sma_pkg::sma_core_st_t cnx;
	sma_pkg::sma_link_st_t lq;
	sma_pkg::sma_link_st_t lnx;
	sma_pkg::sma_cmd_t cmd;
	sma_pkg::sma_cfg_t cfg_now;
	logic ev;
	logic l_en;
	logic scl_h;
	logic sda_h;
	logic rise;
	logic fall;
	logic start_det;
	logic stop_det;
	logic resume;
	logic auto_acknowledge_enable;
	logic active;
	logic hit;
	logic half_done;
	logic raise;

	// Seven address bits compared under the mask; direction bit left out.
	function automatic logic addr_hit(input logic [7:0] rx,
		input sma_pkg::sma_cfg_t c);
		logic masked;
		logic gc;
		masked = ((rx[7:1] ^ c.own[7:1]) & c.mask[7:1]) == 7'h00;
		gc = c.own[sma_pkg::FLD_GC] && (rx[7:1] == sma_pkg::GC_ADDR);
		addr_hit = masked || gc;
	endfunction

	// Pins come straight from link flops; the pin value is always low.
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = lq.scl_rel;
	assign sda_oe_n = lq.sda_rel;
	assign sfr_rdata = cq.rdata;

	// Values the link samples; held still by the register side meanwhile.
	always_comb begin
		cmd = '{begin_request_flag: cq.begin_request_flag, sto: cq.sto, ack: cq.ack, wrote: cq.wrote,
			dat: cq.dat};
		cfg_now = '{own: cq.own, mask: cq.mask, begin_request_flag: cq.begin_request_flag};
	end

	// Event toggle from the link, seen after two flops.
	assign ev = cq.ev_sy[1] ^ cq.ev_sy[2];

	// Register side: decode, flag handling and event capture.
	always_comb begin
		cnx = cq;
		if (clk_en) begin
			cnx.ev_sy = {cq.ev_sy[1:0], lq.evt_tgl};
			cnx.mst_sy = {cq.mst_sy[0], lq.master};
			if (sfr_wr) begin
				case (sfr_addr)
				sma_pkg::ADDR_CTRL: begin
					cnx.begin_request_flag = sfr_wdata[sma_pkg::CB_STA];
					cnx.sto = sfr_wdata[sma_pkg::CB_STO];
					cnx.ack = sfr_wdata[sma_pkg::CB_ACK];
					if (sfr_wdata[sma_pkg::CB_SI]) begin
						cnx.si = 1'b1;
					end else if (cq.si) begin
						// Clearing the flag releases the stalled link.
						cnx.si = 1'b0;
						cnx.res_tgl = ~cq.res_tgl;
						cnx.arbitration_fail_flag = 1'b0;
						cnx.response_needed_flag = 1'b0;
					end
				end
				sma_pkg::ADDR_DATA: begin
					cnx.dat = sfr_wdata;
					cnx.wrote = 1'b1;
				end
				sma_pkg::ADDR_OWN: cnx.own = sfr_wdata;
				sma_pkg::ADDR_MASK: cnx.mask = sfr_wdata;
				default: cnx.dat = cq.dat;
				endcase
			end
			// A generated STOP or a lost arbitration posts no event, so the
			// master bit follows the link's own copy once the flag is clear.
			if (cq.master && !cq.si && !cq.mst_sy[1]) begin
				cnx.master = 1'b0;
				cnx.txmode = 1'b0;
			end
			// An event after a write in the same cycle still wins.
			if (ev) begin
				cnx.si = 1'b1;
				cnx.dat = lq.st.dat;
				cnx.master = lq.st.master;
				cnx.txmode = lq.st.txmode;
				cnx.sta_seen = lq.st.begin_request_flag;
				cnx.sto_seen = lq.st.sto;
				cnx.response_needed_flag = lq.st.response_needed_flag;
				cnx.arbitration_fail_flag = lq.st.arbitration_fail_flag;
				cnx.wrote = 1'b0;
				if (lq.st.txmode) begin
					cnx.ack = lq.st.ack;
				end
			end
			case (sfr_addr)
			sma_pkg::ADDR_CTRL: cnx.rdata = {cq.master, cq.txmode,
				cq.begin_request_flag | cq.sta_seen, cq.sto | cq.sto_seen, cq.response_needed_flag,
				cq.arbitration_fail_flag, cq.ack, cq.si};
			sma_pkg::ADDR_DATA: cnx.rdata = cq.dat;
			sma_pkg::ADDR_OWN: cnx.rdata = cq.own;
			sma_pkg::ADDR_MASK: cnx.rdata = cq.mask;
			default: cnx.rdata = 8'h00;
			endcase
		end
	end

	// Register side state.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cq <= sma_pkg::CORE_RST;
		end else begin
			cq <= cnx;
		end
	end

	// Link helpers; every pin and toggle is read at its second flop.
	always_comb begin
		l_en = lq.en_sy[1];
		scl_h = lq.scl_sy[1];
		sda_h = lq.sda_sy[1];
		rise = l_en && scl_h && !lq.scl_sy[2] && !lq.waiting;
		fall = l_en && !scl_h && lq.scl_sy[2];
		start_det = l_en && scl_h && lq.scl_sy[2] && lq.sda_sy[2] && !sda_h;
		stop_det = l_en && scl_h && lq.scl_sy[2] && !lq.sda_sy[2] && sda_h;
		resume = l_en && lq.waiting && (lq.res_sy[1] ^ lq.res_sy[2]);
		auto_acknowledge_enable = lq.cfg_b.mask[sma_pkg::FLD_AUTO_ACKNOWLEDGE_ENABLE];
		active = lq.master || lq.addressed;
		hit = addr_hit(lq.sh, lq.cfg_b);
		half_done = lq.hcnt >= sma_pkg::SCL_HALF_LAST;
	end

	// Link engine: master clocking, bus events, shifting and events.
	always_comb begin
		lnx = lq;
		raise = 1'b0;
		lnx.en_sy = {lq.en_sy[0], clk_en};
		lnx.scl_sy = {lq.scl_sy[1:0], scl_in};
		lnx.sda_sy = {lq.sda_sy[1:0], sda_in};
		lnx.res_sy = {lq.res_sy[1:0], cq.res_tgl};
		lnx.cfg_a = cfg_now;
		lnx.cfg_b = lq.cfg_a;
		if (l_en) begin
			lnx.hcnt = HCNT_INC(lq.hcnt);
			case (lq.ms)
			sma_pkg::M_IDLE: begin
				lnx.hcnt = '0;
				// Start only on a free, idle bus.
				if (lq.cfg_b.begin_request_flag && !lq.busy && !lq.waiting && scl_h &&
					sda_h) begin
					lnx.ms = sma_pkg::M_ST;
					lnx.sda_rel = 1'b0;
				end
			end
			sma_pkg::M_ST: begin
				if (half_done) begin
					lnx.scl_rel = 1'b0;
					lnx.master = 1'b1;
					lnx.txmode = 1'b1;
					lnx.ms = sma_pkg::M_RUN;
					raise = 1'b1;
				end
			end
			sma_pkg::M_RUN: begin
				// The half count restarts whenever a slave stretches.
				if (lq.waiting) begin
					lnx.scl_rel = 1'b0;
					lnx.hcnt = '0;
				end else if (!lq.scl_rel) begin
					if (half_done) begin
						lnx.scl_rel = 1'b1;
						lnx.hcnt = '0;
					end
				end else if (scl_h) begin
					if (half_done) begin
						lnx.scl_rel = 1'b0;
						lnx.hcnt = '0;
					end
				end else begin
					lnx.hcnt = '0;
				end
			end
			sma_pkg::M_RS1: begin
				lnx.sda_rel = 1'b1;
				if (half_done) begin
					lnx.scl_rel = 1'b1;
					lnx.hcnt = '0;
					lnx.ms = sma_pkg::M_RS2;
				end
			end
			sma_pkg::M_RS2: begin
				if (!scl_h) begin
					lnx.hcnt = '0;
				end else if (half_done) begin
					lnx.sda_rel = 1'b0;
					lnx.hcnt = '0;
					lnx.ms = sma_pkg::M_ST;
				end
			end
			sma_pkg::M_SP1: begin
				lnx.sda_rel = 1'b0;
				if (half_done) begin
					lnx.scl_rel = 1'b1;
					lnx.hcnt = '0;
					lnx.ms = sma_pkg::M_SP2;
				end
			end
			sma_pkg::M_SP2: begin
				if (!scl_h) begin
					lnx.hcnt = '0;
				end else if (half_done) begin
					lnx.sda_rel = 1'b1;
					lnx.master = 1'b0;
					lnx.txmode = 1'b0;
					lnx.ms = sma_pkg::M_IDLE;
				end
			end
			default: lnx.ms = sma_pkg::M_IDLE;
			endcase

			// A START clears any address refusal and opens a new frame.
			if (start_det) begin
				lnx.busy = 1'b1;
				lnx.bit_cnt = 4'h0;
				lnx.addr_ph = 1'b1;
				lnx.addressed = 1'b0;
				lnx.inhib = 1'b0;
				lnx.sta_seen = 1'b1;
				if (lq.ms != sma_pkg::M_ST) begin
					lnx.master = 1'b0;
					lnx.txmode = 1'b0;
					lnx.ms = sma_pkg::M_IDLE;
				end
			end
			if (stop_det) begin
				lnx.busy = 1'b0;
				lnx.bit_cnt = 4'h0;
				if (lq.addressed && !lq.inhib) begin
					lnx.sto_seen = 1'b1;
					raise = 1'b1;
				end
				lnx.addressed = 1'b0;
			end

			if (resume) begin
				lnx.waiting = 1'b0;
				lnx.arbitration_fail_flag = 1'b0;
				lnx.response_needed_flag = 1'b0;
				lnx.hcnt = '0;
				lnx.sta_req = cmd.begin_request_flag;
				lnx.sto_req = cmd.sto;
				lnx.ack_val = cmd.ack;
				if (!lq.master) begin
					lnx.scl_rel = 1'b1;
				end
				if (lq.response_needed_flag) begin
					// Firmware's answer goes out in the ack clock.
					lnx.sda_rel = !cmd.ack;
					if (lq.addr_ph && !lq.master) begin
						lnx.addressed = cmd.ack;
						lnx.inhib = !cmd.ack;
					end
				end else begin
					if (cmd.wrote) begin
						lnx.sh = cmd.dat;
						lnx.txmode = 1'b1;
						lnx.sda_rel = cmd.dat[7];
					end else if (lq.txmode && !lq.addr_ph) begin
						lnx.txmode = 1'b0;
						lnx.sda_rel = 1'b1;
					end
					if (lq.master && cmd.sto) begin
						lnx.ms = sma_pkg::M_SP1;
					end else if (lq.master && cmd.begin_request_flag) begin
						lnx.ms = sma_pkg::M_RS1;
					end
				end
			end else if (rise) begin
				if (lq.bit_cnt < sma_pkg::CNT_ACK) begin
					// Bus data always shifts in, also while sending.
					lnx.sh = {lq.sh[6:0], sda_h};
					if (lq.txmode && lq.sda_rel && !sda_h) begin
						lnx.arbitration_fail_flag = 1'b1;
						lnx.master = 1'b0;
						lnx.txmode = 1'b0;
						lnx.ms = sma_pkg::M_IDLE;
						lnx.scl_rel = 1'b1;
						lnx.sda_rel = 1'b1;
					end
				end else if (lq.txmode) begin
					lnx.ack_rx = !sda_h;
				end
				lnx.bit_cnt = 4'(lq.bit_cnt + 4'h1);
			end else if (fall) begin
				if (lq.bit_cnt == sma_pkg::CNT_ACK) begin
					if (lq.txmode) begin
						lnx.sda_rel = 1'b1;
					end else if (!lq.inhib) begin
						if (lq.addr_ph && !lq.master) begin
							if (!auto_acknowledge_enable) begin
								raise = 1'b1;
								lnx.response_needed_flag = 1'b1;
							end else if (hit) begin
								lnx.addressed = 1'b1;
								lnx.sda_rel = 1'b0;
							end else begin
								lnx.inhib = 1'b1;
							end
						end else if (active) begin
							if (auto_acknowledge_enable) begin
								lnx.sda_rel = !lq.ack_val;
							end else begin
								raise = 1'b1;
								lnx.response_needed_flag = 1'b1;
							end
						end
					end
				end else if (lq.bit_cnt == sma_pkg::CNT_END) begin
					lnx.bit_cnt = 4'h0;
					lnx.sda_rel = 1'b1;
					lnx.addr_ph = 1'b0;
					if (lq.pre) begin
						lnx.pre = 1'b0;
						if (lq.master && lq.sto_req) begin
							lnx.ms = sma_pkg::M_SP1;
						end else if (lq.master && lq.sta_req) begin
							lnx.ms = sma_pkg::M_RS1;
						end
					end else if (active && !lq.inhib) begin
						raise = 1'b1;
					end
				end else if (lq.txmode) begin
					lnx.sda_rel = lq.sh[7];
				end
			end

			// Post an event; except on a STOP the clock is held low until it is cleared.
			if (raise) begin
				lnx.waiting = !stop_det;
				if (!stop_det) begin
					lnx.scl_rel = 1'b0;
				end
				lnx.evt_tgl = ~lq.evt_tgl;
				lnx.st = '{master: lnx.master, txmode: lnx.txmode,
					begin_request_flag: lnx.sta_seen, sto: lnx.sto_seen, response_needed_flag: lnx.response_needed_flag,
					arbitration_fail_flag: lnx.arbitration_fail_flag, ack: lnx.ack_rx, dat: lnx.sh};
				lnx.sta_seen = 1'b0;
				lnx.sto_seen = 1'b0;
				lnx.pre = lnx.response_needed_flag;
			end
		end
	end

	// Half-period counter step.
	function automatic logic [sma_pkg::HCNT_W-1:0] HCNT_INC(
		input logic [sma_pkg::HCNT_W-1:0] v);
		HCNT_INC = sma_pkg::HCNT_W'(v + 1'b1);
	endfunction

	// Link state. The reset is asserted asynchronously in both domains.
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lq <= sma_pkg::LINK_RST;
		end else begin
			lq <= lnx;
		end
	end

	a_si_holds_scl: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		lq.waiting |-> !lq.scl_rel
	) else $error("Clock released while an event is pending.");

	a_data_stable: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		cq.si && $past(cq.si) && !$past(sfr_wr && sfr_addr == sma_pkg::ADDR_DATA)
		|-> cq.dat == $past(cq.dat)
	) else $error("Data register changed while the flag was set.");

	a_msb_shift: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		rise && !resume && lq.bit_cnt < sma_pkg::CNT_ACK
		|=> lq.sh == {$past(lq.sh[6:0]), $past(sda_h)}
	) else $error("Received bit not shifted in at the low end.");

	a_arb_slave: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		rise && !resume && !start_det && lq.bit_cnt < sma_pkg::CNT_ACK &&
		lq.txmode && lq.sda_rel && !sda_h
		|=> !lq.master && !lq.txmode && lq.arbitration_fail_flag && lq.sda_rel
	) else $error("Lost arbitration did not drop to slave receiver.");

	a_addr_ack: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		fall && !resume && lq.bit_cnt == sma_pkg::CNT_ACK && !lq.txmode &&
		!lq.inhib && lq.addr_ph && !lq.master && auto_acknowledge_enable && hit
		|=> lq.addressed && !lq.sda_rel && !lq.waiting
	) else $error("Matching address was not acknowledged.");

	a_addr_nack: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		fall && !resume && lq.bit_cnt == sma_pkg::CNT_ACK && !lq.txmode &&
		!lq.inhib && lq.addr_ph && !lq.master && auto_acknowledge_enable && !hit
		|=> lq.inhib && lq.sda_rel ##1 (lq.inhib && !lq.waiting)
	) else $error("Missed address did not inhibit slave events.");

	a_rx_irq_pre: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		fall && !resume && lq.bit_cnt == sma_pkg::CNT_ACK && !lq.txmode &&
		!lq.inhib && (active || (lq.addr_ph && !lq.master)) && !auto_acknowledge_enable
		|=> lq.waiting && lq.response_needed_flag && !lq.scl_rel
	) else $error("Receiver event not raised before the ack bit.");

	a_tx_irq_post: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		fall && !resume && lq.bit_cnt == sma_pkg::CNT_ACK && lq.txmode
		|=> !lq.waiting && lq.sda_rel
	) else $error("Transmitter event raised before the ack bit.");

	a_start_master: assert property (
		@(posedge link_clk) disable iff (!rst_n)
		l_en && lq.ms == sma_pkg::M_ST && half_done && !start_det
		|=> lq.master && lq.txmode && lq.waiting && !lq.scl_rel
	) else $error("Generated START did not enter master mode.");

	a_event_sets: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		clk_en && ev |=> cq.si && !cq.wrote
	) else $error("Link event did not set the interrupt flag.");
endmodule

// ### src/sma_pkg.sv
// Constants, carrier types and state records for the two-wire serial block.
package sma_pkg;
	// Register port addresses and reset values.
	localparam logic [7:0] ADDR_CTRL = 8'hC0;
	localparam logic [7:0] ADDR_DATA = 8'hC2;
	localparam logic [7:0] ADDR_OWN = 8'hF4;
	localparam logic [7:0] ADDR_MASK = 8'hF5;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_OWN = 8'h00;
	localparam logic [7:0] RST_MASK = 8'hFE;
	// Control register bit positions.
	localparam int CB_MASTER = 7;
	localparam int CB_TXMODE = 6;
	localparam int CB_STA = 5;
	localparam int CB_STO = 4;
	localparam int CB_RESPONSE_NEEDED_FLAG = 3;
	localparam int CB_ARB = 2;
	localparam int CB_ACK = 1;
	localparam int CB_SI = 0;
	// Address field positions and the general call address.
	localparam int FLD_GC = 0;
	localparam int FLD_AUTO_ACKNOWLEDGE_ENABLE = 0;
	localparam logic [6:0] GC_ADDR = 7'h00;
	// Bit counter values: eight data bits, then the ack bit.
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [3:0] CNT_END = 4'h9;
	// Serial clock half period on the link clock.
	localparam int HCNT_W = 10;
	localparam int LINK_PERIOD_PS = 6000;
	localparam int SCL_HALF_NS = 5000;
	localparam logic [HCNT_W-1:0] SCL_HALF_LAST = HCNT_W'(
		(SCL_HALF_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS - 1);

	typedef enum logic [2:0] {
		M_IDLE, M_ST, M_RUN, M_RS1, M_RS2, M_SP1, M_SP2
	} sma_ms_t;

	// Configuration copied into the link domain.
	typedef struct packed {
		logic [7:0] own;
		logic [7:0] mask;
		logic begin_request_flag;
	} sma_cfg_t;

	// Command sampled by the link when the flag is cleared.
	typedef struct packed {
		logic begin_request_flag;
		logic sto;
		logic ack;
		logic wrote;
		logic [7:0] dat;
	} sma_cmd_t;

	// Status snapshot handed to the register side with each event.
	typedef struct packed {
		logic master;
		logic txmode;
		logic begin_request_flag;
		logic sto;
		logic response_needed_flag;
		logic arbitration_fail_flag;
		logic ack;
		logic [7:0] dat;
	} sma_stat_t;

	typedef struct packed {
		logic [7:0] dat;
		logic [7:0] own;
		logic [7:0] mask;
		logic master;
		logic txmode;
		logic begin_request_flag;
		logic sto;
		logic sta_seen;
		logic sto_seen;
		logic response_needed_flag;
		logic arbitration_fail_flag;
		logic ack;
		logic si;
		logic wrote;
		logic res_tgl;
		logic [2:0] ev_sy;
		logic [1:0] mst_sy;
		logic [7:0] rdata;
	} sma_core_st_t;

	typedef struct packed {
		logic [1:0] en_sy;
		logic [2:0] scl_sy;
		logic [2:0] sda_sy;
		logic [2:0] res_sy;
		sma_cfg_t cfg_a;
		sma_cfg_t cfg_b;
		sma_ms_t ms;
		logic [HCNT_W-1:0] hcnt;
		logic [7:0] sh;
		logic [3:0] bit_cnt;
		logic busy;
		logic master;
		logic txmode;
		logic addr_ph;
		logic addressed;
		logic inhib;
		logic waiting;
		logic response_needed_flag;
		logic pre;
		logic arbitration_fail_flag;
		logic ack_rx;
		logic ack_val;
		logic sta_seen;
		logic sto_seen;
		logic sta_req;
		logic sto_req;
		logic scl_rel;
		logic sda_rel;
		logic evt_tgl;
		sma_stat_t st;
	} sma_link_st_t;

	localparam sma_cfg_t CFG_RST = '{own: RST_OWN, mask: RST_MASK, begin_request_flag: 1'b0};
	localparam sma_core_st_t CORE_RST = '{dat: RST_DATA, own: RST_OWN,
		mask: RST_MASK, default: '0};
	localparam sma_link_st_t LINK_RST = '{scl_sy: 3'h7, sda_sy: 3'h7,
		cfg_a: CFG_RST, cfg_b: CFG_RST, ms: M_IDLE, scl_rel: 1'b1,
		sda_rel: 1'b1, default: '0};
endpackage

// ### sim/sma_slave_model.sv
// Behavioural target device that answers the engine on the two-wire bus.
`timescale 1ns/1ps
module sma_slave_model #(
	parameter logic [6:0] TGT_ADDR = 7'h5A
) (
	// Wire levels after the pull-ups.
	input wire logic scl,
	input wire logic sda,
	// High while the model pulls the data line low.
	output logic sda_pull
);
	logic [7:0] rx_last;
	logic ack_seen;
	int ack_cnt;

	// Eight bits sampled on rising clock edges, first bit into the MSB.
	task automatic get(output logic [7:0] v);
		for (int k = 7; k >= 0; k--) begin
			@(posedge scl);
			v[k] = sda;
		end
	endtask

	// Pull the data line for the ack bit; returns on the edge that ends it.
	task automatic give_ack();
		@(negedge scl) #5 sda_pull = 1'b1;
		@(negedge scl);
	endtask

	// One transfer after a START; it parks at the end so only a START ends it.
	task automatic xfer();
		logic [7:0] v;
		logic [7:0] d;
		ack_cnt = 0;
		get(v);
		rx_last = v;
		if (v[7:1] == TGT_ADDR) begin
			give_ack();
			d = 8'hC3;
			forever begin
				if (v[0]) begin
					for (int k = 7; k >= 0; k--) begin
						#5 sda_pull = ~d[k];
						@(negedge scl);
					end
					#5 sda_pull = 1'b0;
					@(posedge scl) ack_seen = sda;
					ack_cnt++;
					d = ~d;
					if (ack_seen === 1'b1) wait (1'b0);
					@(negedge scl);
				end else begin
					#5 sda_pull = 1'b0;
					get(v);
					rx_last = v;
					give_ack();
				end
			end
		end
		wait (1'b0);
	endtask

	// A START aborts whatever was running, so a stop or restart never misframes.
	initial begin
		sda_pull = 1'b0;
		ack_cnt = 0;
		ack_seen = 1'b0;
		rx_last = 8'h00;
		@(negedge sda iff scl === 1'b1);
		forever begin
			fork
				xfer();
				@(negedge sda iff scl === 1'b1);
			join_any
			disable fork;
			sda_pull = 1'b0;
		end
	end
endmodule

// ### sim/test_smbus_addr_match_and_master_xfer.sv
// Self-checking bench for the two-wire engine and its register port.
`timescale 1ns/1ps
module test_smbus_addr_match_and_master_xfer;
	localparam time H = 1000;
	logic core_clk, link_clk, rst_n, sfr_wr;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
	logic scl_oe_n, sda_oe_n, m_pull, bm_scl, bm_sda;
	wire logic scl_w, sda_w;
	int n_errors, cmp_count;

	// Open-drain wires with pull-ups: the engine and bench may pull either line low, the target only the data line.
	assign scl_w = scl_oe_n & ~bm_scl;
	assign sda_w = sda_oe_n & ~m_pull & ~bm_sda;

	sma_addr_xfer i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .link_clk(link_clk), .scl_in(scl_w),
		.scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(),
		.sda_oe_n(sda_oe_n));
	sma_slave_model i_tgt (.scl(scl_w), .sda(sda_w), .sda_pull(m_pull));

	// Two unrelated clocks; the link one starts off-phase.
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
			n_errors++;
		end
	endtask

	// Register write: strobe for one enabled edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge core_clk) #1;
		sfr_wr = 1'b0;
	endtask

	// Register read: data is registered, so it shows one edge later.
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk) #1;
		sfr_addr = a;
		@(posedge core_clk) #1;
		v = sfr_rdata;
	endtask

	// Poll a control bit with a bound; leaves the control byte in v.
	task automatic wait_bit(input int pos, input logic val);
		for (int n = 0; n < 8000; n++) begin
			rd(sma_pkg::ADDR_CTRL);
			if (v[pos] === val) return;
		end
		$display("[FAIL] control bit %0d expected %b seen %b", pos, val, v[pos]);
		n_errors++;
		end_of_test();
	endtask

	task automatic t_reset();
		rd(sma_pkg::ADDR_CTRL);
		chk("control reset", 8'h00, v);
		rd(sma_pkg::ADDR_DATA);
		chk("data reset", 8'h00, v);
		rd(sma_pkg::ADDR_OWN);
		chk("own address reset", 8'h00, v);
		rd(sma_pkg::ADDR_MASK);
		chk("mask reset", 8'hFE, v);
		chk("pins after reset", 8'h03, {4'h0, i_dut.scl_out, i_dut.sda_out,
			scl_oe_n, sda_oe_n});
		wr(8'h80, 8'hFF);
		rd(8'h80);
		chk("unmapped read", 8'h00, v);
		$display("reset test finished");
	endtask

	task automatic t_mwrite();
		wr(sma_pkg::ADDR_MASK, 8'hFF);
		wr(sma_pkg::ADDR_CTRL, 8'h20);
		wait_bit(sma_pkg::CB_SI, 1'b1);
		chk("mode after start", 8'hE0, v & 8'hE0);
		chk("clock stalled", 8'h00, {7'h00, scl_oe_n});
		wr(sma_pkg::ADDR_DATA, 8'hB4);
		wr(sma_pkg::ADDR_CTRL, 8'h00);
		wait_bit(sma_pkg::CB_SI, 1'b1);
		chk("ack after address", 8'hC2, v & 8'hC2);
		chk("address on wire", 8'hB4, i_tgt.rx_last);
		rd(sma_pkg::ADDR_DATA);
		chk("data holds bus byte", 8'hB4, v);
		wr(sma_pkg::ADDR_DATA, 8'h96);
		wr(sma_pkg::ADDR_CTRL, 8'h00);
		wait_bit(sma_pkg::CB_SI, 1'b1);
		chk("ack after data", 8'hC2, v & 8'hC2);
		chk("data on wire", 8'h96, i_tgt.rx_last);
		wr(sma_pkg::ADDR_CTRL, 8'h10);
		wait_bit(sma_pkg::CB_MASTER, 1'b0);
		chk("mode after stop", 8'h00, v & 8'hC0);
		$display("master write test finished");
	endtask

	// Two-byte read; firmware acks or preset ack, last byte NACKed.
	task automatic t_mread(input logic hw);
		wr(sma_pkg::ADDR_MASK, {7'h7F, hw});
		wr(sma_pkg::ADDR_CTRL, 8'h20);
		wait_bit(sma_pkg::CB_SI, 1'b1);
		wr(sma_pkg::ADDR_DATA, 8'hB5);
		wr(sma_pkg::ADDR_CTRL, 8'h00);
		wait_bit(sma_pkg::CB_SI, 1'b1);
		chk("read address acked", 8'h02, v & 8'h02);
		wr(sma_pkg::ADDR_CTRL, 8'h02);
		wait_bit(sma_pkg::CB_SI, 1'b1);
		chk("receiver status", {4'h8, ~hw, 3'h1}, v & 8'hC9);
		chk("acks before event", {7'h0, hw}, i_tgt.ack_cnt[7:0]);
		rd(sma_pkg::ADDR_DATA);
		chk("first byte", 8'hC3, v);
		wr(sma_pkg::ADDR_CTRL, {6'h00, ~hw, 1'b0});
		wait_bit(sma_pkg::CB_SI, 1'b1);
		rd(sma_pkg::ADDR_DATA);
		chk("second byte", 8'h3C, v);
		chk("acks seen", hw ? 8'h05 : 8'h02,
			{i_tgt.ack_cnt[6:0], i_tgt.ack_seen});
		wr(sma_pkg::ADDR_CTRL, 8'h10);
		wait_bit(sma_pkg::CB_MASTER, 1'b0);
		chk("last byte nacked", 8'h05,
			{i_tgt.ack_cnt[6:0], i_tgt.ack_seen});
		chk("receiver left", 8'h00, v & 8'hC0);
		$display("master read test finished");
	endtask

	// Bench acts as a bus master and offers one address byte.
	task automatic try_addr(input logic [6:0] a, input logic exp);
		logic [7:0] b;
		logic ak;
		b = {a, 1'b0};
		bm_sda = 1'b1;
		#H bm_scl = 1'b1;
		for (int k = 7; k >= 0; k--) begin
			#H bm_sda = ~b[k];
			#H bm_scl = 1'b0;
			#H bm_scl = 1'b1;
		end
		#H bm_sda = 1'b0;
		#H bm_scl = 1'b0;
		#H ak = ~sda_w;
		bm_scl = 1'b1;
		#H rd(sma_pkg::ADDR_CTRL);
		chk("address ack", {7'h0, exp}, {7'h0, ak});
		chk("slave event", {7'h0, exp}, {7'h0, v[0]});
		wr(sma_pkg::ADDR_CTRL, 8'h00);
		bm_sda = 1'b1;
		#H bm_scl = 1'b0;
		#H bm_sda = 1'b0;
		#H wr(sma_pkg::ADDR_CTRL, 8'h00);
	endtask

	task automatic t_slave();
		wr(sma_pkg::ADDR_OWN, 8'h68);
		wr(sma_pkg::ADDR_MASK, 8'hFD);
		try_addr(7'h34, 1'b1);
		try_addr(7'h35, 1'b1);
		try_addr(7'h36, 1'b0);
		try_addr(7'h00, 1'b0);
		wr(sma_pkg::ADDR_OWN, 8'h69);
		try_addr(7'h00, 1'b1);
		wr(sma_pkg::ADDR_OWN, 8'hE0);
		wr(sma_pkg::ADDR_MASK, 8'hE7);
		try_addr(7'h7C, 1'b1);
		try_addr(7'h71, 1'b0);
		$display("address recognition test finished");
	endtask

	// Bench holds the data line low so the first address bit is lost.
	task automatic t_arb();
		wr(sma_pkg::ADDR_CTRL, 8'h20);
		wait_bit(sma_pkg::CB_SI, 1'b1);
		wr(sma_pkg::ADDR_DATA, 8'hFE);
		bm_sda = 1'b1;
		wr(sma_pkg::ADDR_CTRL, 8'h00);
		wait_bit(sma_pkg::CB_MASTER, 1'b0);
		chk("mode after loss", 8'h00, v & 8'hC0);
		chk("lines after loss", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
		bm_sda = 1'b0;
		#H rd(sma_pkg::ADDR_CTRL);
		$display("arbitration test finished");
	endtask

	// Main sequence.
	initial begin
		n_errors = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		bm_scl = 1'b0;
		bm_sda = 1'b0;
		repeat (5) @(posedge core_clk);
		#1 rst_n = 1'b1;
		t_reset();
		t_mwrite();
		t_mread(1'b0);
		t_mread(1'b1);
		t_slave();
		t_arb();
		end_of_test();
	end
endmodule
